// ---- rtl/spen_event_notify.sv ----
// Per-port event detection, status capture and notification
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module spen_event_notify
    import spen_pkg::*;
#(
    parameter int CNT_W = 16,       // Egress and ingress queue counter width
    parameter int PARINFO_W = 16    // Lookup failure info width
) (
    input wire logic hclk, // Core clock
    input wire logic hresetn, // Async reset, active low
    input wire logic clk_en, // Freezes all state when low
    input wire logic hsel, // AHB select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic hready, // AHB bus ready
    input wire logic [31:0] hwdata, // AHB write data
    output logic [31:0] hrdata, // AHB read data
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response
    input wire logic pkt_retry, // Packet retried
    input wire logic pkt_accept, // Packet acceptance received
    input wire logic rx_pkt_valid, // Inbound packet header valid
    input wire logic rx_lut_unmapped, // Lookup entry unmapped
    input wire logic rx_tt_reserved, // Reserved transport type
    input wire logic rx_is_maint, // Maintenance packet
    input wire logic [7:0] rx_hop_count, // Maintenance hop count
    input wire logic lut_parity_err, // Parity fault during lookup
    input wire logic [PARINFO_W-1:0] lut_parity_info, // Failing lookup info
    input wire logic [7:0] err_rate_count, // Error rate counter
    input wire logic rx_reset_symbol, // Reset request symbol received
    input wire logic rx_other_symbol, // Any other control symbol
    input wire logic rx_mcast_symbol, // Multicast event symbol
    input wire logic egress_over_pulse, // Egress queue over threshold
    input wire logic ingress_over_pulse, // Ingress queue over threshold
    input wire logic reorder_pulse, // Packet reordered
    input wire logic pw_ready, // Port-write sender accepts
    output logic pw_valid, // Port-write request
    output logic [SPEN_NPW-1:0] pw_events, // Events carried in port-write
    output logic event_int_n // Interrupt, active low
);
    // Register state
    logic [1:0] ctrl;
    logic [15:0] retry_thr;
    logic [7:0] fail_thr;
    logic [7:0] deg_thr;
    logic [15:0] egress_thr;
    logic [15:0] ingress_thr;
    logic [15:0] reorder_thr;
    logic [SPEN_NEV-1:0] port_stat;
    logic [SPEN_NEV-1:0] int_en;
    logic [SPEN_NPW-1:0] pw_en;
    logic vendor_error_detect_flag;
    logic [1:0] csym_stat;
    logic [1:0] global_stat;
    logic [PARINFO_W-1:0] parity_info;
    // Counters
    logic [15:0] retry_cnt;
    logic [CNT_W-1:0] egress_cnt;
    logic [CNT_W-1:0] ingress_cnt;
    logic [15:0] reorder_cnt;
    logic [2:0] reset_run;
    logic fail_seen;
    logic deg_seen;
    // Bus pipeline
    logic dp_write;
    logic dp_read;
    logic [SPEN_ADDR_W-1:0] dp_addr;
    logic [SPEN_NPW-1:0] pw_pending;
    // Event pulses
    logic [SPEN_NEV-1:0] ev;
    logic ev_retry;
    logic ev_badtr;
    logic ev_fail;
    logic ev_deg;
    logic ev_reset;
    logic wr_port_stat;
    logic wr_csym;
    logic wr_global;
    logic [31:0] next_hrdata;

    // Retry reaches threshold
    assign ev_retry = pkt_retry && ((retry_cnt + 16'h0001) >= retry_thr);
    // Unmapped lookup or reserved type
    assign ev_badtr = rx_pkt_valid && (rx_lut_unmapped ||
        (rx_tt_reserved && (!rx_is_maint || (rx_hop_count != 8'h00))));
    // Error rate thresholds, edge of reaching
    assign ev_fail = (err_rate_count >= fail_thr) && !fail_seen;
    assign ev_deg = (err_rate_count >= deg_thr) && !deg_seen;
    // Fourth consecutive reset symbol
    assign ev_reset = rx_reset_symbol && (reset_run == SPEN_RESET_RUN - 3'h1);

    // Collected event vector
    always_comb begin
        ev = '0;
        ev[SPEN_EV_RETRY] = ev_retry;
        ev[SPEN_EV_BADTR] = ev_badtr;
        ev[SPEN_EV_PARITY] = lut_parity_err;
        ev[SPEN_EV_FAIL] = ev_fail;
        ev[SPEN_EV_DEG] = ev_deg;
        ev[SPEN_EV_EGRESS] = egress_over_pulse &&
            ((egress_cnt + 1'b1) >= CNT_W'(egress_thr));
        ev[SPEN_EV_INGRESS] = ingress_over_pulse &&
            ((ingress_cnt + 1'b1) >= CNT_W'(ingress_thr));
        ev[SPEN_EV_REORDER] = reorder_pulse &&
            ((reorder_cnt + 16'h0001) >= reorder_thr);
        ev[SPEN_EV_RESET] = ev_reset;
        ev[SPEN_EV_MCAST] = rx_mcast_symbol;
    end

    // Write strobes decoded in data phase
    assign wr_port_stat = dp_write && (dp_addr == SPEN_PORT_STAT_ADDR);
    assign wr_csym = dp_write && (dp_addr == SPEN_CSYM_STAT_ADDR);
    assign wr_global = dp_write && (dp_addr == SPEN_GLOBAL_STAT_ADDR);

    // AHB address phase capture, zero wait states for writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= '0;
        end else if (clk_en && hready) begin
            dp_write <= hsel && htrans[1] && hwrite;
            dp_read <= hsel && htrans[1] && !hwrite;
            dp_addr <= haddr[SPEN_ADDR_W-1:0];
        end
    end

    // One wait state per read, so registered data meets the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (clk_en) begin
            hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
            hresp <= 1'b0;
        end
    end

    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= 2'h3;
            retry_thr <= SPEN_RETRY_THR_RST;
            fail_thr <= SPEN_ERR_FAIL_RST;
            deg_thr <= SPEN_ERR_DEG_RST;
            egress_thr <= SPEN_QUEUE_THR_RST;
            ingress_thr <= SPEN_QUEUE_THR_RST;
            reorder_thr <= SPEN_REORDER_THR_RST;
            int_en <= '0;
            pw_en <= '0;
        end else if (clk_en && dp_write) begin
            case (dp_addr)
                SPEN_CTRL_ADDR: ctrl <= hwdata[1:0];
                SPEN_RETRY_THR_ADDR: retry_thr <= hwdata[15:0];
                SPEN_ERR_THR_ADDR: begin
                    fail_thr <= hwdata[15:8];
                    deg_thr <= hwdata[7:0];
                end
                SPEN_QUEUE_THR_ADDR: begin
                    egress_thr <= hwdata[31:16];
                    ingress_thr <= hwdata[15:0];
                end
                SPEN_REORDER_THR_ADDR: reorder_thr <= hwdata[15:0];
                SPEN_INT_EN_ADDR: int_en <= hwdata[SPEN_NEV-1:0];
                SPEN_PW_EN_ADDR: pw_en <= hwdata[SPEN_NPW-1:0];
                default: ;
            endcase
        end
    end

    // Shared retry counter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            retry_cnt <= '0;
        end else if (clk_en) begin
            if (pkt_accept || ev_retry) begin
                retry_cnt <= '0;
            end else if (pkt_retry) begin
                retry_cnt <= retry_cnt + 16'h0001;
            end
        end
    end

    // Queue and reorder counters, restart on reaching threshold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            egress_cnt <= '0;
            ingress_cnt <= '0;
            reorder_cnt <= '0;
        end else if (clk_en) begin
            if (ev[SPEN_EV_EGRESS]) begin
                egress_cnt <= '0;
            end else if (egress_over_pulse) begin
                egress_cnt <= egress_cnt + 1'b1;
            end
            if (ev[SPEN_EV_INGRESS]) begin
                ingress_cnt <= '0;
            end else if (ingress_over_pulse) begin
                ingress_cnt <= ingress_cnt + 1'b1;
            end
            if (ev[SPEN_EV_REORDER]) begin
                reorder_cnt <= '0;
            end else if (reorder_pulse) begin
                reorder_cnt <= reorder_cnt + 16'h0001;
            end
        end
    end

    // Consecutive reset symbol run; other symbols break it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_run <= '0;
        end else if (clk_en) begin
            if (ev_reset || rx_other_symbol || rx_mcast_symbol) begin
                reset_run <= '0;
            end else if (rx_reset_symbol) begin
                reset_run <= reset_run + 3'h1;
            end
        end
    end

    // Threshold crossing memory for error rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fail_seen <= 1'b0;
            deg_seen <= 1'b0;
        end else if (clk_en) begin
            fail_seen <= err_rate_count >= fail_thr;
            deg_seen <= err_rate_count >= deg_thr;
        end
    end

    // Sticky port status, set wins over write-one-to-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_stat <= '0;
        end else if (clk_en) begin
            port_stat <= (port_stat & ~(wr_port_stat ? hwdata[SPEN_NEV-1:0] : '0))
                | ev;
        end
    end

    // Vendor error detect bit for retry, bad transaction and parity events
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vendor_error_detect_flag <= 1'b0;
        end else if (clk_en) begin
            if (ev_retry || ev_badtr || lut_parity_err) begin
                vendor_error_detect_flag <= 1'b1;
            end else if (dp_write && (dp_addr == SPEN_ERR_DETECT_ADDR) && hwdata[0]) begin
                vendor_error_detect_flag <= 1'b0;
            end
        end
    end

    // Lookup parity failure info, first failure held
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            parity_info <= '0;
        end else if (clk_en && lut_parity_err && !port_stat[SPEN_EV_PARITY]) begin
            parity_info <= lut_parity_info;
        end
    end

    // Control symbol and global status bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            csym_stat <= '0;
            global_stat <= '0;
        end else if (clk_en) begin
            csym_stat[SPEN_CS_RESET] <= ev_reset ||
                (csym_stat[SPEN_CS_RESET] && !(wr_csym && hwdata[SPEN_CS_RESET]));
            csym_stat[SPEN_CS_MCAST] <= rx_mcast_symbol ||
                (csym_stat[SPEN_CS_MCAST] && !(wr_csym && hwdata[SPEN_CS_MCAST]));
            global_stat[SPEN_CS_RESET] <= ev_reset ||
                (global_stat[SPEN_CS_RESET] && !(wr_global && hwdata[SPEN_CS_RESET]));
            global_stat[SPEN_CS_MCAST] <= rx_mcast_symbol ||
                (global_stat[SPEN_CS_MCAST] && !(wr_global && hwdata[SPEN_CS_MCAST]));
        end
    end

    // Interrupt from any enabled pending status
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_int_n <= 1'b1;
        end else if (clk_en) begin
            event_int_n <= !(ctrl[SPEN_CTRL_INT_GLOBAL] && |(port_stat & int_en));
        end
    end

    // Port-write request; reset and multicast events never included
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pw_pending <= '0;
            pw_valid <= 1'b0;
            pw_events <= '0;
        end else if (clk_en) begin
            if (pw_valid && pw_ready) begin
                pw_valid <= 1'b0;
                pw_pending <= ev[SPEN_NPW-1:0] & pw_en;
            end else if (!pw_valid && (|pw_pending) && ctrl[SPEN_CTRL_PW_GLOBAL]) begin
                pw_valid <= 1'b1;
                pw_events <= pw_pending;
                pw_pending <= ev[SPEN_NPW-1:0] & pw_en;
            end else begin
                pw_pending <= pw_pending | (ev[SPEN_NPW-1:0] & pw_en);
            end
        end
    end

    // Read mux
    always_comb begin
        next_hrdata = '0;
        case (dp_addr)
            SPEN_CTRL_ADDR: next_hrdata[1:0] = ctrl;
            SPEN_RETRY_THR_ADDR: next_hrdata[15:0] = retry_thr;
            SPEN_ERR_THR_ADDR: next_hrdata[15:0] = {fail_thr, deg_thr};
            SPEN_QUEUE_THR_ADDR: next_hrdata = {egress_thr, ingress_thr};
            SPEN_REORDER_THR_ADDR: next_hrdata[15:0] = reorder_thr;
            SPEN_PORT_STAT_ADDR: next_hrdata[SPEN_NEV-1:0] = port_stat;
            SPEN_ERR_DETECT_ADDR: next_hrdata = {PARINFO_W'(parity_info), 15'h0000,
                vendor_error_detect_flag};
            SPEN_CSYM_STAT_ADDR: next_hrdata[1:0] = csym_stat;
            SPEN_GLOBAL_STAT_ADDR: next_hrdata[1:0] = global_stat;
            SPEN_INT_EN_ADDR: next_hrdata[SPEN_NEV-1:0] = int_en;
            SPEN_PW_EN_ADDR: next_hrdata[SPEN_NPW-1:0] = pw_en;
            SPEN_COUNT_ADDR: next_hrdata = {reorder_cnt, retry_cnt};
            default: next_hrdata = '0;
        endcase
    end

    // Read data loaded in the wait state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= '0;
        end else if (clk_en && hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= '0;
        end else if (clk_en && dp_read && !hreadyout) begin
            hrdata <= next_hrdata;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/spen_pkg.sv ----
// Constants for the switch port event notification block
package spen_pkg;
    // Register byte offsets
    localparam logic [7:0] SPEN_CTRL_ADDR = 8'h00;
    localparam logic [7:0] SPEN_RETRY_THR_ADDR = 8'h04;
    localparam logic [7:0] SPEN_ERR_THR_ADDR = 8'h08;
    localparam logic [7:0] SPEN_QUEUE_THR_ADDR = 8'h0C;
    localparam logic [7:0] SPEN_REORDER_THR_ADDR = 8'h10;
    localparam logic [7:0] SPEN_PORT_STAT_ADDR = 8'h14;
    localparam logic [7:0] SPEN_ERR_DETECT_ADDR = 8'h18;
    localparam logic [7:0] SPEN_CSYM_STAT_ADDR = 8'h1C;
    localparam logic [7:0] SPEN_GLOBAL_STAT_ADDR = 8'h20;
    localparam logic [7:0] SPEN_INT_EN_ADDR = 8'h24;
    localparam logic [7:0] SPEN_PW_EN_ADDR = 8'h28;
    localparam logic [7:0] SPEN_COUNT_ADDR = 8'h2C;
    localparam int SPEN_ADDR_W = 8;
    // Event bit positions in port status, enables and port-write code
    localparam int SPEN_EV_RETRY = 0;
    localparam int SPEN_EV_BADTR = 1;
    localparam int SPEN_EV_PARITY = 2;
    localparam int SPEN_EV_FAIL = 3;
    localparam int SPEN_EV_DEG = 4;
    localparam int SPEN_EV_EGRESS = 5;
    localparam int SPEN_EV_INGRESS = 6;
    localparam int SPEN_EV_REORDER = 7;
    localparam int SPEN_EV_RESET = 8;
    localparam int SPEN_EV_MCAST = 9;
    localparam int SPEN_NEV = 10;
    localparam int SPEN_NPW = 8;
    // Control symbol / global bit positions
    localparam int SPEN_CS_RESET = 0;
    localparam int SPEN_CS_MCAST = 1;
    // Reset values and counts
    localparam logic [15:0] SPEN_REORDER_THR_RST = 16'hFFFF;
    localparam logic [15:0] SPEN_RETRY_THR_RST = 16'h0010;
    localparam logic [7:0] SPEN_ERR_FAIL_RST = 8'hFF;
    localparam logic [7:0] SPEN_ERR_DEG_RST = 8'hFF;
    localparam logic [15:0] SPEN_QUEUE_THR_RST = 16'hFFFF;
    localparam logic [2:0] SPEN_RESET_RUN = 3'h4;
    // Control register bits
    localparam int SPEN_CTRL_INT_GLOBAL = 0;
    localparam int SPEN_CTRL_PW_GLOBAL = 1;
endpackage

// ---- tb/spen_event_notify_properties.sv ----
// Checker of notification timing at the block ports
`timescale 1ns/10ps
`default_nettype none
module spen_event_notify_checker
    import spen_pkg::*;
(
    input wire logic hclk, // Core clock
    input wire logic hresetn, // Reset, active low
    input wire logic hsel, // Bus select
    input wire logic [31:0] haddr, // Bus address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic hready, // Bus ready
    input wire logic [31:0] hwdata, // Write data
    input wire logic hreadyout, // Slave ready
    input wire logic hresp, // Response
    input wire logic rx_pkt_valid, // Packet valid
    input wire logic rx_lut_unmapped, // Unmapped entry
    input wire logic rx_reset_symbol, // Reset symbol
    input wire logic rx_other_symbol, // Other symbol
    input wire logic rx_mcast_symbol, // Multicast symbol
    input wire logic pw_ready, // Sender accepts
    input wire logic pw_valid, // Port-write request
    input wire logic [SPEN_NPW-1:0] pw_events, // Port-write events
    input wire logic event_int_n // Interrupt, active low
);
    logic wdp;
    logic [7:0] wa;
    logic [1:0] ctrl_s;
    logic [9:0] ien_s;
    logic [7:0] pwen_s;
    logic [9:0] ie;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Effective interrupt enables
    assign ie = ien_s & {10{ctrl_s[0]}};
    // Note write data phases and shadow the enables
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdp <= 1'b0;
            wa <= 8'h00;
            ctrl_s <= 2'h3;
            ien_s <= 10'h000;
            pwen_s <= 8'h00;
        end else begin
            wdp <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) wa <= haddr[7:0];
            if (wdp && wa == SPEN_CTRL_ADDR) ctrl_s <= hwdata[1:0];
            if (wdp && wa == SPEN_INT_EN_ADDR) ien_s <= hwdata[9:0];
            if (wdp && wa == SPEN_PW_EN_ADDR) pwen_s <= hwdata[7:0];
        end
    end
    hresp_okay_a: assert property (!hresp && (hreadyout || $past(hreadyout)))
        else $error("bus answer late or not OKAY");
    pw_hold_a: assert property (pw_valid && !pw_ready |=> pw_valid && $stable(pw_events))
        else $error("port-write not held");
    int_quiet_a: assert property (!ctrl_s[0] && !$past(ctrl_s[0]) |-> event_int_n)
        else $error("interrupt while disabled");
    bad_int_a: assert property (rx_pkt_valid && rx_lut_unmapped && ie[1] |-> ##2 !event_int_n)
        else $error("bad transaction gave no interrupt");
    reset_run_a: assert property ((rx_reset_symbol && !rx_other_symbol && !rx_mcast_symbol)[*4] ##0 ie[8] |-> ##[2:3] !event_int_n)
        else $error("reset symbol run gave no interrupt");
    mcast_int_a: assert property (rx_mcast_symbol && ie[9] |-> ##2 !event_int_n)
        else $error("multicast symbol gave no interrupt");
    int_sticky_a: assert property (!event_int_n && !wdp && !$past(wdp) |=> !event_int_n)
        else $error("interrupt dropped without a write");
    pw_send_a: assert property (rx_pkt_valid && rx_lut_unmapped && ctrl_s[1] && pwen_s[1] |-> ##[1:40] (pw_valid && pw_events[1]))
        else $error("bad transaction sent no port-write");
endmodule
bind spen_event_notify spen_event_notify_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .rx_pkt_valid(rx_pkt_valid),
    .rx_lut_unmapped(rx_lut_unmapped), .rx_reset_symbol(rx_reset_symbol),
    .rx_other_symbol(rx_other_symbol), .rx_mcast_symbol(rx_mcast_symbol),
    .pw_ready(pw_ready), .pw_valid(pw_valid), .pw_events(pw_events), .event_int_n(event_int_n));
`default_nettype wire

// ---- tb/spen_pw_sink.sv ----
// Model of the port-write sender beyond the block
`timescale 1ns/10ps
`default_nettype none
module spen_pw_sink
    import spen_pkg::*;
(
    input wire logic hclk, // Core clock
    input wire logic hresetn, // Reset, active low
    input wire logic slow, // Accept one cycle in four
    input wire logic pw_valid, // Port-write request
    input wire logic [SPEN_NPW-1:0] pw_events, // Events carried
    output logic pw_ready, // Sender accepts
    output var int n_pw, // Port-writes taken
    output logic [SPEN_NPW-1:0] last_ev // Events of the last one
);
    logic [1:0] gap;
    // Ready moves just after an edge; a taken request is counted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap <= 2'h0;
            pw_ready <= 1'b0;
            n_pw <= 0;
            last_ev <= '0;
        end else begin
            gap <= gap + 2'h1;
            pw_ready <= !slow || gap == 2'h3;
            if (pw_valid && pw_ready) begin
                n_pw <= n_pw + 1;
                last_ev <= pw_events;
            end
        end
    end
endmodule
`default_nettype wire

// ---- tb/tb_spen_event_notify.sv ----
// Self-checking bench for the port event notification block
`timescale 1ns/10ps
`default_nettype none
module tb_spen_event_notify
    import spen_pkg::*;
;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
    logic rxv = 1'b0, unm = 1'b0, ttr = 1'b0, mnt = 1'b0;
    logic hreadyout, hresp, pw_ready, pw_valid, event_int_n;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rng = 32'h5AD59D7B;
    logic [15:0] pinfo = 16'h0;
    logic [7:0] hop = 8'h0, err_rate = 8'h0;
    logic [SPEN_NPW-1:0] pw_ev, last_ev;
    logic [8:0] pul = 9'h000;
    int n_fail = 0, comparisons = 0, n_pw, n0;
    logic [7:0] ra [6] = '{SPEN_CTRL_ADDR, SPEN_RETRY_THR_ADDR, SPEN_ERR_THR_ADDR,
        SPEN_QUEUE_THR_ADDR, SPEN_REORDER_THR_ADDR, 8'h40};
    logic [31:0] rv [6] = '{32'h3, 32'h10, 32'hFFFF, 32'hFFFFFFFF, 32'hFFFF, 32'h0};
    logic [7:0] er [4] = '{8'h0F, 8'h10, 8'h1F, 8'h20};
    logic [31:0] ef [4] = '{32'h0, 32'h10, 32'h10, 32'h18};
    int qk [3] = '{5, 6, 7};
    int qt [3] = '{2, 3, 2};
    spen_event_notify u_spen_event_notify (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pkt_retry(pul[0]), .pkt_accept(pul[1]), .rx_pkt_valid(rxv),
        .rx_lut_unmapped(unm), .rx_tt_reserved(ttr), .rx_is_maint(mnt), .rx_hop_count(hop),
        .lut_parity_err(pul[8]), .lut_parity_info(pinfo), .err_rate_count(err_rate),
        .rx_reset_symbol(pul[2]), .rx_other_symbol(pul[3]), .rx_mcast_symbol(pul[4]),
        .egress_over_pulse(pul[5]), .ingress_over_pulse(pul[6]), .reorder_pulse(pul[7]),
        .pw_ready(pw_ready), .pw_valid(pw_valid), .pw_events(pw_ev), .event_int_n(event_int_n));
    spen_pw_sink u_spen_pw_sink (.hclk(hclk), .hresetn(hresetn), .slow(slow),
        .pw_valid(pw_valid), .pw_events(pw_ev), .pw_ready(pw_ready), .n_pw(n_pw),
        .last_ev(last_ev));
    // Core clock
    initial begin
        forever #2 hclk = ~hclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic bad_exp(input logic u, t, m, input logic [7:0] h);
        return u || (t && (!m || h != 8'h00));
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_pin(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic wrdy();
        int i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 16);
        if (hreadyout !== 1'b1) begin
            n_fail++;
            conclude();
        end
    endtask
    task automatic ap(input logic [7:0] a, input logic w);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wrdy();
        htrans <= 2'h0;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        ap(a, 1'b1);
        hwdata <= d;
        wrdy();
    endtask
    task automatic bus_rd(input logic [7:0] a);
        ap(a, 1'b0);
        wrdy();
        rd = hrdata;
    endtask
    task automatic sbit(input string nm, input logic [7:0] a, input int b, input logic e);
        bus_rd(a);
        chk_pin(nm, e, rd[b]);
    endtask
    task automatic pin(input string nm, input logic e);
        @(posedge hclk);
        #1 chk_pin(nm, e, event_int_n);
    endtask
    task automatic pulse(input int k, input int n);
        @(posedge hclk);
        pul[k] <= 1'b1;
        repeat (n) @(posedge hclk);
        pul <= 9'h000;
    endtask
    task automatic pkt(input logic u, t, m, input logic [7:0] h);
        @(posedge hclk);
        rxv <= 1'b1;
        unm <= u;
        ttr <= t;
        mnt <= m;
        hop <= h;
        @(posedge hclk);
        rxv <= 1'b0;
    endtask
    task automatic clr();
        bus_wr(SPEN_PORT_STAT_ADDR, 32'hFFFFFFFF);
        bus_wr(SPEN_ERR_DETECT_ADDR, 32'h1);
        bus_wr(SPEN_CSYM_STAT_ADDR, 32'h3);
        bus_wr(SPEN_GLOBAL_STAT_ADDR, 32'h3);
    endtask
    // Hang guard
    initial begin
        repeat (100000) @(posedge hclk);
        n_fail++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ra[i]) begin
            bus_rd(ra[i]);
            chk_reg("reset value", rv[i], rd);
        end
        bus_wr(SPEN_INT_EN_ADDR, 32'h3FF);
        bus_wr(SPEN_PW_EN_ADDR, 32'hFF);
        $display("reset value test done");
        bus_wr(SPEN_RETRY_THR_ADDR, 32'h3);
        pulse(0, 2);
        pulse(1, 1);
        pulse(0, 2);
        bus_rd(SPEN_COUNT_ADDR);
        chk_reg("retry count", 32'h2, {16'h0, rd[15:0]});
        sbit("retry flag early", SPEN_PORT_STAT_ADDR, SPEN_EV_RETRY, 1'b0);
        pulse(0, 1);
        sbit("retry flag", SPEN_PORT_STAT_ADDR, SPEN_EV_RETRY, 1'b1);
        sbit("vendor error", SPEN_ERR_DETECT_ADDR, 0, 1'b1);
        bus_rd(SPEN_COUNT_ADDR);
        chk_reg("retry count", 32'h0, {16'h0, rd[15:0]});
        clr();
        $display("retry test done");
        n0 = n_pw;
        pkt(1'b1, 1'b0, 1'b0, 8'h00);
        repeat (8) @(posedge hclk);
        chk_pin("port-write sent", 1'b1, n_pw > n0 && last_ev[SPEN_EV_BADTR]);
        sbit("vendor error", SPEN_ERR_DETECT_ADDR, 0, 1'b1);
        clr();
        slow <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            rng = xs(rng);
            rd = i < 2 ? {16'h0, i == 0 ? 8'h00 : rng[15:8], 8'h06} : rng;
            pkt(rd[0], rd[1], rd[2], rd[15:8]);
            sbit("bad transaction", SPEN_PORT_STAT_ADDR, SPEN_EV_BADTR,
                bad_exp(rd[0], rd[1], rd[2], rd[15:8]));
            clr();
        end
        $display("bad transaction test done");
        rng = xs(rng);
        pinfo <= rng[15:0];
        pulse(8, 1);
        bus_rd(SPEN_ERR_DETECT_ADDR);
        chk_reg("parity info", {rng[15:0], 16'h0001}, rd);
        sbit("parity flag", SPEN_PORT_STAT_ADDR, SPEN_EV_PARITY, 1'b1);
        bus_wr(SPEN_ERR_THR_ADDR, 32'h2010);
        foreach (er[i]) begin
            err_rate <= er[i];
            bus_rd(SPEN_PORT_STAT_ADDR);
            chk_reg("error rate flags", ef[i], rd & 32'h18);
        end
        err_rate <= 8'h00;
        clr();
        $display("parity and error rate test done");
        n0 = n_pw;
        pulse(2, 3);
        pulse(3, 1);
        pulse(2, 3);
        sbit("reset request early", SPEN_CSYM_STAT_ADDR, SPEN_CS_RESET, 1'b0);
        pulse(2, 4);
        sbit("reset request", SPEN_CSYM_STAT_ADDR, SPEN_CS_RESET, 1'b1);
        sbit("global reset", SPEN_GLOBAL_STAT_ADDR, SPEN_CS_RESET, 1'b1);
        pulse(4, 1);
        sbit("multicast symbol", SPEN_CSYM_STAT_ADDR, SPEN_CS_MCAST, 1'b1);
        sbit("global multicast", SPEN_GLOBAL_STAT_ADDR, SPEN_CS_MCAST, 1'b1);
        repeat (8) @(posedge hclk);
        chk_reg("port-write count", 32'(n0), 32'(n_pw));
        $display("control symbol test done");
        bus_wr(SPEN_QUEUE_THR_ADDR, 32'h00020003);
        bus_wr(SPEN_REORDER_THR_ADDR, 32'h2);
        foreach (qk[i]) begin
            pulse(qk[i], qt[i] - 1);
            sbit("queue flag early", SPEN_PORT_STAT_ADDR, qk[i], 1'b0);
            pulse(qk[i], 1);
            sbit("queue flag", SPEN_PORT_STAT_ADDR, qk[i], 1'b1);
        end
        clr();
        pin("interrupt idle", 1'b1);
        bus_wr(SPEN_CTRL_ADDR, 32'h2);
        pulse(4, 1);
        pin("interrupt masked", 1'b1);
        bus_wr(SPEN_CTRL_ADDR, 32'h3);
        pin("interrupt", 1'b0);
        repeat (6) @(posedge hclk);
        pin("interrupt held", 1'b0);
        clr();
        pin("interrupt cleared", 1'b1);
        $display("queue and interrupt test done");
        conclude();
    end
endmodule
`default_nettype wire
